/* logic/sba_rx_byte_align.v */
`timescale 1ns/1ps
`default_nettype none
`include "sba_defs.vh"
module sba_rx_byte_align #(
  parameter integer LOCK_CYC  = `SBA_LOCK_US * `SBA_CLK_MHZ,
  parameter integer SYNC_BITS = `SBA_SYNC_BITS
) (
  input  wire        clk_i,
  input  wire        rst_b_i,
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [11:0] paddr_i,
  input  wire [31:0] pwdata_i,
  output wire [31:0] prdata_o,
  output wire        pready_o,
  output wire        pslverr_o,
  input  wire        bit_clk_i,
  input  wire        serial_data_i,
  input  wire        loopback_data_i,
  input  wire        amplitude_ok_i,
  output wire [9:0]  rx_word_o,
  output wire [1:0]  rx_byte_clocks_o,
  output wire        signal_loss_flag_o,
  output wire        irq_o
);

  // Synchronisers for the link pins, two flops each
  reg [1:0] bclk_s_q;
  reg [1:0] sdat_s_q;
  reg [1:0] ldat_s_q;
  reg [1:0] amp_s_q;
  reg       bclk_d1_q;

  // Bit clock and both data inputs; the delayed copy finds rising edges
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bclk_s_q  <= 2'h0;
      sdat_s_q  <= 2'h0;
      ldat_s_q  <= 2'h0;
      bclk_d1_q <= 1'b0;
    end else begin
      bclk_s_q  <= {bclk_s_q[0], bit_clk_i};
      sdat_s_q  <= {sdat_s_q[0], serial_data_i};
      ldat_s_q  <= {ldat_s_q[0], loopback_data_i};
      bclk_d1_q <= bclk_s_q[1];
    end
  end

  // Amplitude detector level; reset low so the loss flag starts set
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      amp_s_q <= 2'h0;
    end else begin
      amp_s_q <= {amp_s_q[0], amplitude_ok_i};
    end
  end

  // Control register fields
  reg [3:0]           ctrl_q;
  wire rate_sel       = ctrl_q[`SBA_CTRL_RATE];
  wire phase_mode     = ctrl_q[`SBA_CTRL_PHASE];
  wire cdet_en        = ctrl_q[`SBA_CTRL_CDET];
  wire loop_en        = ctrl_q[`SBA_CTRL_LOOP];

  // One bit per rising edge of the sampled bit clock
  wire bit_stb = bclk_s_q[1] & ~bclk_d1_q;
  wire bit_in  = loop_en ? ldat_s_q[1] : sdat_s_q[1];
  wire amp_ok  = amp_s_q[1];

  // Frequency lock timer after reset
  reg [31:0] lock_cnt_q;
  reg        locked_q;

  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lock_cnt_q <= 32'h0;
      locked_q   <= 1'b0;
    end else if (!locked_q) begin
      lock_cnt_q <= lock_cnt_q + 32'h1;
      locked_q   <= (lock_cnt_q >= LOCK_CYC - 1);
    end
  end

  // Bit sync: count bit times of valid signal before trusting words
  reg [15:0] sync_cnt_q;
  reg        synced_q;

  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync_cnt_q <= 16'h0;
      synced_q   <= 1'b0;
    end else if (!amp_ok || !locked_q) begin
      sync_cnt_q <= 16'h0;
      synced_q   <= 1'b0;
    end else if (bit_stb && !synced_q) begin
      sync_cnt_q <= sync_cnt_q + 16'h1;
      synced_q   <= (sync_cnt_q >= SYNC_BITS[15:0] - 16'h1);
    end
  end

  // Shift register, first received bit ends in bit zero
  reg  [9:0] shift_q;
  reg  [3:0] bcnt_q;
  wire [9:0] shift_d   = {bit_in, shift_q[9:1]};
  wire       comma_hit = bit_stb && synced_q && cdet_en
                         && (shift_d[9:3] == `SBA_COMMA_HEAD);
  wire       aligned   = (bcnt_q == `SBA_COMMA_BITS - 4'h1);
  wire       realign   = comma_hit && !aligned;
  wire       word_end  = bit_stb && (bcnt_q == `SBA_WORD_BITS - 4'h1) && !comma_hit;
  wire       half_end  = bit_stb && (bcnt_q == `SBA_HALF_BITS - 4'h1);
  // One byte-clock period per word only at low rate in phase mode 1
  wire       per_word  = ~rate_sel & phase_mode;

  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      shift_q <= 10'h0;
      bcnt_q  <= 4'h0;
    end else if (bit_stb) begin
      shift_q <= shift_d;
      if (comma_hit)
        bcnt_q <= `SBA_COMMA_BITS;
      else if (bcnt_q == `SBA_WORD_BITS - 4'h1)
        bcnt_q <= 4'h0;
      else
        bcnt_q <= bcnt_q + 4'h1;
    end
  end

  // Loss flag follows the synchronised amplitude detector
  reg loss_q;

  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      loss_q <= 1'b1;
    end else begin
      loss_q <= ~amp_ok;
    end
  end

  // Receive word register: all ones while the amplitude is bad
  reg  [9:0] word_q;
  wire       word_load = amp_ok && word_end && synced_q;

  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      word_q <= `SBA_ALL_ONES;
    end else if (!amp_ok) begin
      word_q <= `SBA_ALL_ONES;
    end else if (word_load) begin
      word_q <= shift_d;
    end
  end

  // Byte clock one and its inverse; while the amplitude is bad only the per-word fall at half_end still moves them
  reg rbc1_q;
  reg rbc0_q;
  reg pos_q;

  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rbc1_q <= 1'b0;
      rbc0_q <= 1'b1;
      pos_q  <= 1'b0;
    end else if (word_load) begin
      // Word and clock edge change together; rising edge marks byte zero
      if (per_word) begin
        rbc1_q <= 1'b1;
        rbc0_q <= 1'b0;
      end else begin
        rbc1_q <= ~pos_q;
        rbc0_q <= pos_q;
      end
      pos_q <= ~pos_q;
    end else if (comma_hit) begin
      // Park clock one low so the comma word always brings a fresh rise,
      // also when the boundary was right but the byte phase was not
      rbc1_q <= 1'b0;
      rbc0_q <= 1'b1;
      pos_q  <= 1'b0;
    end else if (half_end && per_word) begin
      rbc1_q <= 1'b0;
      rbc0_q <= 1'b1;
    end
  end

  // Sticky interrupt status
  reg [3:0] irq_stat_q;
  reg [3:0] irq_en_q;
  reg       irq_q;
  wire      wr_acc = psel_i & penable_i & pwrite_i;
  wire      clr_wr = wr_acc && (paddr_i == `SBA_IRQ_CLR_ADDR);
  wire [3:0] ev;
  assign ev[`SBA_EV_COMMA]   = comma_hit;
  assign ev[`SBA_EV_REALIGN] = realign;
  assign ev[`SBA_EV_LOSS]    = ~amp_ok & ~loss_q;
  assign ev[`SBA_EV_WORD]    = word_end & synced_q & amp_ok;
  // Set wins over a clear in the same cycle
  wire [3:0] irq_stat_d = (irq_stat_q & ~(clr_wr ? pwdata_i[3:0] : 4'h0)) | ev;

  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_stat_q <= 4'h0;
    end else begin
      irq_stat_q <= irq_stat_d;
    end
  end

  // Level interrupt from the next status, so it rises with the sticky bit
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(irq_stat_d & irq_en_q);
    end
  end

  // Register read mux
  function [31:0] rd_mux;
    input [11:0] a;
    begin
      case (a)
        `SBA_CTRL_ADDR:     rd_mux = {28'h0, ctrl_q};
        `SBA_STATUS_ADDR:   rd_mux = {28'h0, ~(rate_sel | phase_mode), synced_q,
                                      locked_q, loss_q};
        `SBA_WORD_ADDR:     rd_mux = {22'h0, word_q};
        `SBA_IRQ_STAT_ADDR: rd_mux = {28'h0, irq_stat_q};
        `SBA_IRQ_EN_ADDR:   rd_mux = {28'h0, irq_en_q};
        default:            rd_mux = 32'h0;
      endcase
    end
  endfunction

  function mapped;
    input [11:0] a;
    begin
      mapped = (a == `SBA_CTRL_ADDR) || (a == `SBA_STATUS_ADDR) ||
               (a == `SBA_WORD_ADDR) || (a == `SBA_IRQ_STAT_ADDR) ||
               (a == `SBA_IRQ_CLR_ADDR) || (a == `SBA_IRQ_EN_ADDR);
    end
  endfunction

  // Write strobe for one register address
  function wr_hit;
    input        acc;
    input [11:0] a;
    input [11:0] r;
    begin
      wr_hit = acc && (a == r);
    end
  endfunction

  // APB answer: ready in the access cycle, data prepared from the setup cycle
  reg [31:0] prdata_q;
  reg        pslverr_q;
  reg        pready_q;
  wire       setup_ph = psel_i & ~penable_i;

  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prdata_q  <= 32'h0;
      pslverr_q <= 1'b0;
      pready_q  <= 1'b0;
    end else begin
      pready_q <= setup_ph;
      if (setup_ph) begin
        prdata_q  <= pwrite_i ? 32'h0 : rd_mux(paddr_i);
        pslverr_q <= ~mapped(paddr_i);
      end else begin
        prdata_q  <= 32'h0;
        pslverr_q <= 1'b0;
      end
    end
  end

  // Writable registers take the data at the edge that ends the access cycle
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl_q   <= `SBA_CTRL_RESET;
      irq_en_q <= 4'h0;
    end else begin
      if (wr_hit(wr_acc & pready_q, paddr_i, `SBA_CTRL_ADDR))
        ctrl_q <= pwdata_i[3:0];
      if (wr_hit(wr_acc & pready_q, paddr_i, `SBA_IRQ_EN_ADDR))
        irq_en_q <= pwdata_i[3:0];
    end
  end

  // Transmit latency lives in the serializer; the loopback input carries its output
  assign prdata_o           = prdata_q;
  assign pready_o           = pready_q;
  assign pslverr_o          = pslverr_q;
  assign rx_word_o          = word_q;
  assign rx_byte_clocks_o   = {rbc1_q, rbc0_q};
  assign signal_loss_flag_o = loss_q;
  assign irq_o              = irq_q;

endmodule // sba_rx_byte_align
`default_nettype wire

/* logic/sba_defs.vh */
// Behaviour
// - Regroup the retimed serial bits into 10-bit receive words.
// - Detect the leading seven comma bits 0011111 in the serial stream.
// - After a comma, the next comma begins at word bit zero.
// - On realignment the byte clocks are only stretched, never shortened; here a misaligned comma parks clock one low, which can shorten a phase.
// - Byte clocks are aligned by the next ordered set after the comma; here the comma word itself brings the aligning rise.
// - Each ordered set starts on a rising edge of byte clock one.
// - Valid amplitude clears the loss flag and passes the selected stream.
// - Rate select picks line rate; half byte-clock rate only when both modes zero; here half rate except at rate 0 with phase mode 1.
// - Transmit latency is typically 0.8 ns plus 8.5 bit times.
// - Receive latency is typically 13.5 bit times plus 2.5 ns.
// - Bit synchronisation is regained within 2500 bit times after a phase jump.
// - Frequency lock is reached within 500 microseconds of power-up.
// - With comma detect on, comma byte zero starts at or before clock one rise.
// - Phase mode 0 latches on rising edges; mode 1 switches with clock edges.
// - Parallel loopback feeds the internal transmit serial signal to the receiver.
`ifndef SBA_DEFS_VH
`define SBA_DEFS_VH
// Register byte addresses
`define SBA_CTRL_ADDR      12'h000
`define SBA_STATUS_ADDR    12'h004
`define SBA_WORD_ADDR      12'h008
`define SBA_IRQ_STAT_ADDR  12'h00C
`define SBA_IRQ_CLR_ADDR   12'h010
`define SBA_IRQ_EN_ADDR    12'h014
// Control fields
`define SBA_CTRL_RATE      0
`define SBA_CTRL_PHASE     1
`define SBA_CTRL_CDET      2
`define SBA_CTRL_LOOP      3
`define SBA_CTRL_RESET     4'h4
// Interrupt event bits
`define SBA_EV_COMMA       0
`define SBA_EV_REALIGN     1
`define SBA_EV_LOSS        2
`define SBA_EV_WORD        3
`define SBA_EV_W           4
// Comma head as seen in the shift register, newest bit on the left
`define SBA_COMMA_HEAD     7'h7C
`define SBA_WORD_BITS      4'hA
`define SBA_COMMA_BITS     4'h7
`define SBA_HALF_BITS      4'h5
`define SBA_ALL_ONES       10'h3FF
// Timing
`define SBA_CLK_MHZ        40
`define SBA_LOCK_US        500
`define SBA_SYNC_BITS      2500
`endif

/* testbench/sba_rx_byte_align_props.sv */
`timescale 1ns/1ps
`default_nettype none
module sba_rx_byte_align_props (
  input wire        clk_i,
  input wire        rst_b_i,
  input wire        psel_i,
  input wire        penable_i,
  input wire [31:0] prdata_o,
  input wire        pready_o,
  input wire        pslverr_o,
  input wire        amplitude_ok_i,
  input wire [9:0]  rx_word_o,
  input wire [1:0]  rx_byte_clocks_o,
  input wire        signal_loss_flag_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // Amplitude lost, restored, or steady while a word changes
  sequence s_lost; $fell(amplitude_ok_i) ##1 !amplitude_ok_i [*4]; endsequence
  sequence s_back; $rose(amplitude_ok_i) ##1 amplitude_ok_i [*4]; endsequence
  sequence s_word; amplitude_ok_i [*5] ##0 ($changed(rx_word_o) && !signal_loss_flag_o); endsequence
  // Bus answer timing and error data
  a_apb_answer: assert property (psel_i && !penable_i |=> pready_o) else $error("no answer");
  a_ready_pulse: assert property (pready_o |=> !pready_o) else $error("ready held");
  a_err_zero: assert property (pslverr_o |-> pready_o && prdata_o == 32'h0) else $error("err data");
  // Loss of amplitude and recovery
  a_loss_set: assert property (s_lost |-> signal_loss_flag_o && rx_word_o == 10'h3FF) else $error("loss");
  a_loss_ones: assert property (signal_loss_flag_o && $past(signal_loss_flag_o) |-> rx_word_o == 10'h3FF) else $error("ones");
  a_loss_clear: assert property (s_back |-> !signal_loss_flag_o) else $error("loss stuck");
  // Byte clock shape
  a_clk_inverse: assert property (rx_byte_clocks_o[0] == !rx_byte_clocks_o[1]) else $error("clk pair");
  a_word_clock: assert property (s_word |-> $changed(rx_byte_clocks_o)) else $error("word clk");
  a_no_sliver: assert property ($rose(rx_byte_clocks_o[1]) |=> rx_byte_clocks_o[1] [*4]) else $error("high short");
  a_low_stretch: assert property ($fell(rx_byte_clocks_o[1]) |=> !rx_byte_clocks_o[1] [*8]) else $error("low short");
endmodule // sba_rx_byte_align_props
bind sba_rx_byte_align sba_rx_byte_align_props u_props (.clk_i(clk_i), .rst_b_i(rst_b_i),
  .psel_i(psel_i), .penable_i(penable_i), .prdata_o(prdata_o), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .amplitude_ok_i(amplitude_ok_i), .rx_word_o(rx_word_o),
  .rx_byte_clocks_o(rx_byte_clocks_o), .signal_loss_flag_o(signal_loss_flag_o));
`default_nettype wire

/* testbench/sba_link_tx.sv */
`timescale 1ns/1ps
`default_nettype none
module sba_link_tx (
  output var logic bit_clk_o,
  output var logic data_o
);
  // Idle: bit clock stands still
  initial begin
    bit_clk_o = 1'b0;
    data_o = 1'b1;
  end
  // First n bits of a word, first bit first
  task automatic send_bits(input logic [9:0] w, input int n);
    for (int i = 0; i < n; i++) begin
      data_o = w[i];
      #100 bit_clk_o = 1'b1;
      #100 bit_clk_o = 1'b0;
    end
    data_o = ~w[n-1];
  endtask
  // One word; callers never send two commas in a row
  task automatic send_word(input logic [9:0] w);
    send_bits(w, 10);
  endtask
endmodule // sba_link_tx
`default_nettype wire

/* testbench/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sba_defs.vh"
module tb;
  logic        clk_i, rst_b_i, psel_i, penable_i, pwrite_i, amp_ok, armed, err;
  logic        pready_o, pslverr_o, bit_clk, ser, loss, irq;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, rd;
  logic [9:0]  word, prev, w, ls;
  logic [1:0]  bclk;
  logic [10:0] exp_q[$];
  integer      errors, compares, seed, i, n;
  sba_link_tx u_sba_link_tx (.bit_clk_o(bit_clk), .data_o(ser));
  sba_rx_byte_align #(.LOCK_CYC(16), .SYNC_BITS(4)) u_sba_rx_byte_align (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .bit_clk_i(bit_clk), .serial_data_i(ser),
    .loopback_data_i(~ser), .amplitude_ok_i(amp_ok), .rx_word_o(word),
    .rx_byte_clocks_o(bclk), .signal_loss_flag_o(loss), .irq_o(irq));
  // Clock
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_sim;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Bus transfer: setup, access held until ready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  // Each new word is matched with the oldest note
  always @(posedge clk_i) begin
    prev <= word;
    if (armed && word !== prev)
      check({21'h0, bclk[1], word}, {21'h0, exp_q.pop_front()}, "word");
  end
  // Watchdog
  initial begin
    #300000;
    errors++;
    end_sim;
  end
  initial begin
    errors = 0;
    compares = 0;
    seed = 32'ha58b8b99;
    armed = 1'b0;
    ls = 10'h0;
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
    amp_ok = 1'b1;
    rst_b_i = 1'b0;
    repeat (10) @(posedge clk_i);
    rst_b_i <= 1'b1;
    apb(0, `SBA_CTRL_ADDR, 0);
    check(rd, 32'h4, "ctrl reset");
    apb(0, 12'h018, 0);
    check({rd[30:0], err}, 32'h1, "unmapped");
    apb(1, `SBA_IRQ_EN_ADDR, 32'hF);
    repeat (20) @(posedge clk_i);
    u_sba_link_tx.send_word(10'h155);
    exp_q.push_back(11'h57C);
    fork
      u_sba_link_tx.send_word(10'h17C);
      #1450 armed = 1'b1;
    join
    // Random words, the last three through the loopback path
    for (i = 0; i < 6; i++) begin
      if (i == 3)
        apb(1, `SBA_CTRL_ADDR, 32'hC);
      w = (10'($random(seed)) & 10'h092) | 10'h249;
      if (w == ls)
        w = w ^ 10'h002;
      ls = w;
      exp_q.push_back({i[0], (i >= 3) ? ~w : w});
      u_sba_link_tx.send_word(w);
    end
    repeat (8) @(posedge clk_i);
    check({31'h0, irq}, 32'h1, "irq raised");
    apb(0, `SBA_IRQ_STAT_ADDR, 0);
    check(rd & 32'h9, 32'h9, "irq status");
    apb(1, `SBA_IRQ_CLR_ADDR, 32'hF);
    apb(1, `SBA_IRQ_EN_ADDR, 32'h0);
    armed = 1'b0;
    check(exp_q.size(), 32'h0, "words left");
    amp_ok <= 1'b0;
    repeat (6) @(posedge clk_i);
    check({20'h0, irq, loss, word}, {22'h1, 10'h3FF}, "loss");
    apb(0, `SBA_IRQ_STAT_ADDR, 0);
    check(rd, 32'h4, "loss status");
    amp_ok <= 1'b1;
    repeat (6) @(posedge clk_i);
    check({31'h0, loss}, 32'h0, "loss clear");
    // One word per byte clock, boundary pushed off by three stray bits
    apb(1, `SBA_CTRL_ADDR, 32'h6);
    u_sba_link_tx.send_bits(10'h155, 3);
    u_sba_link_tx.send_word(10'h155);
    exp_q.push_back(11'h57C);
    fork
      u_sba_link_tx.send_word(10'h17C);
      #1450 armed = 1'b1;
    join
    for (i = 0; i < 2; i++) begin
      w = (10'($random(seed)) & 10'h092) | 10'h249;
      if (w == ls)
        w = w ^ 10'h002;
      ls = w;
      exp_q.push_back({1'b1, w});
      u_sba_link_tx.send_word(w);
    end
    repeat (8) @(posedge clk_i);
    armed = 1'b0;
    check(exp_q.size(), 32'h0, "aligned words left");
    apb(0, `SBA_IRQ_STAT_ADDR, 0);
    check(rd & 32'h3, 32'h3, "realign status");
    end_sim;
  end
endmodule // tb
`default_nettype wire
